/* File: design/bit_sync.sv */
// two-flop synchroniser for a group of inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] first;
      logic [W-1:0] second;
   } sync_t;

   sync_t s;
   sync_t n;

   // the first stage feeds the second stage only
   always_comb begin
      n.first = din;
      n.second = s.first;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign dout = s.second;
endmodule : bit_sync
`default_nettype wire

/* File: design/debug_reset_strategy_sequencer.sv */
// reset-and-halt sequencer that drives target debug register accesses and the reset pin
//
// How it works
// - every strategy runs over either transport and ends with the target cpu halted.
// - strategy zero is the default and runs the strategy eight sequence unless boot rom handling is enabled.
// - the core reset vector catch is armed before any reset except on the boot rom path and in strategy three, so the core stops before application code.
// - a full reset sets the system reset request bit, resetting core and peripherals.
// - after a reset the reset sticky status is polled high, then low, and then the vector catch is cleared unless the boot rom path is taken.
// - strategy one resets only the core with the local core reset request, vector catch armed first.
// - strategy two pulls the reset pin low, with vector catch armed beforehand.
// - strategy three holds the reset pin low throughout the connection steps.
// - strategy four resets everything, lets the boot rom run, then halts before the application.
// - strategy five resets everything and halts at once, never letting the boot rom run.
// - strategy six runs the default sequence and then disables the watchdog.
// - strategy seven issues a system reset, lets the kernel run, then halts.
// - strategy nine resets, halts after the boot rom, disables the watchdog, and warns on a slow link.
// - strategy ten resets with vector catch armed and then disables the watchdog.
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module debug_reset_strategy_sequencer
   import reset_seq_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register port
   input wire logic [REG_AW-1:0] regAddr,
   input wire logic [DW-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DW-1:0] regRdata,
   // target memory access, four-phase handshake to the transport engine
   output logic apReq,
   output logic apWrite,
   output logic [DW-1:0] apAddr,
   output logic [DW-1:0] apWdata,
   input wire logic apAck,
   input wire logic [DW-1:0] apRdata,
   output logic linkSwd,
   // link clock as seen on the pin
   input wire logic linkClk,
   // target reset pin, open drain
   output logic tgtResetOut,
   output logic tgtResetOe,
   // interrupt
   output logic irq
);
   localparam int SYNC_W = DW + 2;

   typedef struct packed {
      seq_state_t st;
      logic [STRAT_W-1:0] strat;
      logic swdSel;
      logic bootRom;
      logic [CNT_W-1:0] pollLimit;
      logic [CNT_W-1:0] bootWait;
      logic [DW-1:0] wdogAddr;
      logic [DW-1:0] wdogData;
      logic [IRQ_W-1:0] irqEn;
      logic [IRQ_W-1:0] irqStat;
      logic irq;
      logic [DW-1:0] rdData;
      logic req;
      logic waitAck;
      logic write;
      logic [DW-1:0] addr;
      logic [DW-1:0] wdata;
      logic [DW-1:0] lastRdata;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] pollCnt;
      logic rstOut;
      logic rstOe;
      logic vcArmed;
      logic bootPath;
      logic busy;
      logic halted;
      logic failed;
   } state_t;

   localparam state_t RESET_S = '{st: S_IDLE, pollLimit: POLL_LIMIT_DEF,
                                  bootWait: BOOT_WAIT_DEF, default: '0};

   state_t s;
   state_t n;
   logic [SYNC_W-1:0] syncOut;
   logic linkClkS;
   logic ackS;
   logic [DW-1:0] rdataS;
   logic slowLink;
   logic startReq;
   logic accDone;
   logic finish;
   logic fail;
   logic [IRQ_W-1:0] evSet;
   logic [IRQ_W-1:0] evClr;

   function automatic logic isAccess(input seq_state_t st);
      return (st == S_VC) || (st == S_RST) || (st == S_POLLHI) || (st == S_POLLLO) ||
             (st == S_HALT) || (st == S_CLRVC) || (st == S_WDOG);
   endfunction : isAccess

   function automatic logic needWdog(input logic [STRAT_W-1:0] strat);
      return (strat == STRAT_WDOG_A) || (strat == STRAT_BOOT_WDOG) || (strat == STRAT_WDOG_B);
   endfunction : needWdog

   function automatic logic bootStrat(input logic [STRAT_W-1:0] strat, input logic bootRom);
      return (strat == STRAT_AFTER_BOOT) || (strat == STRAT_KERNEL) ||
             (strat == STRAT_BOOT_WDOG) || ((strat == STRAT_NORMAL) && bootRom);
   endfunction : bootStrat

   function automatic logic [DW-1:0] accAddr(input seq_state_t st, input logic [DW-1:0] wdog);
      if ((st == S_VC) || (st == S_CLRVC)) begin
         return ADDR_DEBUG_EXC_MON_CTRL;
      end else if (st == S_RST) begin
         return ADDR_APP_INT_RST_CTRL;
      end else if (st == S_WDOG) begin
         return wdog;
      end
      return ADDR_DEBUG_HALT_CTRL_STATUS;
   endfunction : accAddr

   function automatic logic [DW-1:0] accData(input seq_state_t st,
                                             input logic [STRAT_W-1:0] strat,
                                             input logic [DW-1:0] wdog);
      if (st == S_VC) begin
         return CORE_RESET_VECTOR_CATCH;
      end else if (st == S_RST) begin
         if (strat == STRAT_CORE) begin
            return RST_CTRL_KEY | LOCAL_CORE_RESET_REQUEST;
         end
         return RST_CTRL_KEY | SYSTEM_RESET_REQUEST;
      end else if (st == S_HALT) begin
         return HALT_CTRL_KEY | HALT_REQUEST | HALT_DEBUG_EN;
      end else if (st == S_WDOG) begin
         return wdog;
      end
      return '0;
   endfunction : accData

   // ack, read data and the link clock all come from the transport clock domain
   bit_sync #(.W(SYNC_W)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .din({linkClk, apAck, apRdata}),
      .dout(syncOut)
   );

   assign linkClkS = syncOut[SYNC_W-1];
   assign ackS = syncOut[DW];
   assign rdataS = syncOut[DW-1:0];

   link_rate_monitor u_rate (
      .core_clk(core_clk),
      .rst(rst),
      .linkClkSync(linkClkS),
      .slowLink(slowLink)
   );

   always_comb begin
      n = s;
      startReq = 1'b0;
      finish = 1'b0;
      fail = 1'b0;
      evSet = '0;
      evClr = '0;
      n.rdData = '0;
      n.rstOut = 1'b0;
      accDone = s.waitAck && !ackS;
      // register writes; only the control register is frozen while a sequence runs
      if (regWr) begin
         if (regAddr == OFF_CTRL) begin
            if (!s.busy) begin
               n.strat = regWdata[CTRL_STRAT_LSB +: STRAT_W];
               n.swdSel = regWdata[CTRL_SWD_BIT];
               n.bootRom = regWdata[CTRL_BOOTROM_BIT];
               startReq = regWdata[CTRL_START_BIT];
            end
         end else if (regAddr == OFF_POLL_LIMIT) begin
            n.pollLimit = regWdata[CNT_W-1:0];
         end else if (regAddr == OFF_BOOT_WAIT) begin
            n.bootWait = regWdata[CNT_W-1:0];
         end else if (regAddr == OFF_WDOG_ADDR) begin
            n.wdogAddr = regWdata;
         end else if (regAddr == OFF_WDOG_DATA) begin
            n.wdogData = regWdata;
         end else if (regAddr == OFF_IRQ_CLEAR) begin
            evClr = regWdata[IRQ_W-1:0];
         end else if (regAddr == OFF_IRQ_ENABLE) begin
            n.irqEn = regWdata[IRQ_W-1:0];
         end
      end
      // register reads, unmapped offsets read zero
      if (regRd) begin
         if (regAddr == OFF_CTRL) begin
            n.rdData[CTRL_STRAT_LSB +: STRAT_W] = s.strat;
            n.rdData[CTRL_SWD_BIT] = s.swdSel;
            n.rdData[CTRL_BOOTROM_BIT] = s.bootRom;
         end else if (regAddr == OFF_STATUS) begin
            n.rdData[STAT_BUSY_BIT] = s.busy;
            n.rdData[STAT_HALTED_BIT] = s.halted;
            n.rdData[STAT_FAILED_BIT] = s.failed;
            n.rdData[STAT_SLOW_BIT] = slowLink;
         end else if (regAddr == OFF_POLL_LIMIT) begin
            n.rdData[CNT_W-1:0] = s.pollLimit;
         end else if (regAddr == OFF_BOOT_WAIT) begin
            n.rdData[CNT_W-1:0] = s.bootWait;
         end else if (regAddr == OFF_WDOG_ADDR) begin
            n.rdData = s.wdogAddr;
         end else if (regAddr == OFF_WDOG_DATA) begin
            n.rdData = s.wdogData;
         end else if (regAddr == OFF_IRQ_STATUS) begin
            n.rdData[IRQ_W-1:0] = s.irqStat;
         end else if (regAddr == OFF_IRQ_ENABLE) begin
            n.rdData[IRQ_W-1:0] = s.irqEn;
         end else if (regAddr == OFF_LAST_RDATA) begin
            n.rdData = s.lastRdata;
         end
      end
      // four-phase handshake: raise req, drop on ack, done when ack falls
      if (isAccess(s.st)) begin
         if (!s.req && !s.waitAck) begin
            n.req = 1'b1;
            n.write = (s.st != S_POLLHI) && (s.st != S_POLLLO);
            n.addr = accAddr(s.st, s.wdogAddr);
            n.wdata = accData(s.st, s.strat, s.wdogData);
         end else if (s.req && ackS) begin
            n.req = 1'b0;
            n.waitAck = 1'b1;
            n.lastRdata = rdataS;
         end else if (accDone) begin
            n.waitAck = 1'b0;
         end
      end
      case (s.st)
         S_IDLE: begin
            if (startReq) begin
               n.busy = 1'b1;
               n.halted = 1'b0;
               n.failed = 1'b0;
               n.cnt = '0;
               n.pollCnt = '0;
               n.bootPath = bootStrat(n.strat, n.bootRom);
               if (n.strat > STRAT_MAX) begin
                  fail = 1'b1;
               end else if (n.strat == STRAT_UNDER_RST) begin
                  n.rstOe = 1'b1;
                  n.st = S_PIN;
               end else if (bootStrat(n.strat, n.bootRom)) begin
                  n.st = S_RST;
               end else begin
                  n.st = S_VC;
               end
               if ((n.strat == STRAT_BOOT_WDOG) && slowLink) begin
                  evSet[IRQ_SLOW] = 1'b1;
               end
            end
         end
         S_PIN: begin
            n.cnt = s.cnt + 16'h0001;
            if (s.cnt == PIN_HOLD_CYC - 16'h0001) begin
               n.cnt = '0;
               if (s.strat == STRAT_UNDER_RST) begin
                  n.st = S_VC;
               end else begin
                  n.rstOe = 1'b0;
                  n.st = S_POLLHI;
               end
            end
         end
         S_VC: begin
            if (accDone) begin
               n.vcArmed = 1'b1;
               if (s.strat == STRAT_UNDER_RST) begin
                  n.rstOe = 1'b0;
                  n.st = S_POLLHI;
               end else if (s.strat == STRAT_PIN) begin
                  n.rstOe = 1'b1;
                  n.st = S_PIN;
               end else begin
                  n.st = S_RST;
               end
            end
         end
         S_RST: begin
            if (accDone) begin
               n.st = S_POLLHI;
            end
         end
         S_POLLHI, S_POLLLO: begin
            if (accDone) begin
               n.pollCnt = s.pollCnt + 16'h0001;
               if ((s.st == S_POLLHI) && s.lastRdata[RESET_STICKY_STATUS_BIT]) begin
                  n.st = S_POLLLO;
               end else if ((s.st == S_POLLLO) && !s.lastRdata[RESET_STICKY_STATUS_BIT]) begin
                  n.st = s.bootPath ? S_BOOT : S_CLRVC;
               end else if (n.pollCnt >= s.pollLimit) begin
                  fail = 1'b1;
               end
            end
         end
         S_BOOT: begin
            // the boot rom or kernel runs freely for the programmed time
            n.cnt = s.cnt + 16'h0001;
            if (s.cnt >= s.bootWait) begin
               n.cnt = '0;
               n.st = S_HALT;
            end
         end
         S_HALT, S_CLRVC: begin
            if (accDone) begin
               if (s.st == S_CLRVC) begin
                  n.vcArmed = 1'b0;
               end
               if (needWdog(s.strat)) begin
                  n.st = S_WDOG;
               end else begin
                  finish = 1'b1;
               end
            end
         end
         S_WDOG: begin
            if (accDone) begin
               finish = 1'b1;
            end
         end
         default: begin
            n.st = S_IDLE;
         end
      endcase
      if (finish) begin
         n.st = S_IDLE;
         n.busy = 1'b0;
         n.halted = 1'b1;
         evSet[IRQ_DONE] = 1'b1;
      end
      if (fail) begin
         n.st = S_IDLE;
         n.busy = 1'b0;
         n.failed = 1'b1;
         n.rstOe = 1'b0;
         n.vcArmed = 1'b0;
         evSet[IRQ_FAIL] = 1'b1;
      end
      // a new event wins over a clear in the same cycle
      n.irqStat = (s.irqStat & ~evClr) | evSet;
      n.irq = |(n.irqStat & n.irqEn);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s <= RESET_S;
      end else begin
         s <= n;
      end
   end

   assign regRdata = s.rdData;
   assign apReq = s.req;
   assign apWrite = s.write;
   assign apAddr = s.addr;
   assign apWdata = s.wdata;
   assign linkSwd = s.swdSel;
   assign tgtResetOut = s.rstOut;
   assign tgtResetOe = s.rstOe;
   assign irq = s.irq;

   vcBeforeReset_a: assert property (@(posedge core_clk) disable iff (rst)
      ($rose(s.req) && s.addr == ADDR_APP_INT_RST_CTRL && !s.bootPath) |-> s.vcArmed)
      else $error("reset issued without vector catch armed");
   sysReset_a: assert property (@(posedge core_clk) disable iff (rst)
      ($rose(s.req) && s.addr == ADDR_APP_INT_RST_CTRL && s.strat != STRAT_CORE)
      |-> s.wdata == (RST_CTRL_KEY | SYSTEM_RESET_REQUEST))
      else $error("full reset does not carry system reset request");
   coreReset_a: assert property (@(posedge core_clk) disable iff (rst)
      ($rose(s.req) && s.addr == ADDR_APP_INT_RST_CTRL && s.strat == STRAT_CORE)
      |-> s.wdata == (RST_CTRL_KEY | LOCAL_CORE_RESET_REQUEST))
      else $error("core reset does not carry local core reset request");
   pollOrder_a: assert property (@(posedge core_clk) disable iff (rst)
      (s.st == S_CLRVC && $past(s.st) != S_CLRVC) |-> $past(s.st) == S_POLLLO)
      else $error("vector catch cleared before reset status fell");
   pinHold_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(s.rstOe) |-> s.rstOe[*8])
      else $error("reset pin pulse too short");
   underReset_a: assert property (@(posedge core_clk) disable iff (rst)
      (s.strat == STRAT_UNDER_RST && s.st == S_VC) |-> s.rstOe)
      else $error("reset pin released during connect under reset");
   bootOnly_a: assert property (@(posedge core_clk) disable iff (rst)
      (s.st == S_BOOT) |-> s.strat != STRAT_BEFORE_BOOT && s.strat != STRAT_SYSTEM)
      else $error("boot rom allowed to run for a halt-at-once strategy");
   bootHalt_a: assert property (@(posedge core_clk) disable iff (rst)
      (s.st == S_BOOT && s.cnt >= s.bootWait) |=> s.st == S_HALT ##[1:300] $rose(s.req))
      else $error("no halt request after the boot rom ran");
   wdogOnly_a: assert property (@(posedge core_clk) disable iff (rst)
      (s.st == S_WDOG && s.req) |-> needWdog(s.strat) && s.addr == s.wdogAddr)
      else $error("watchdog step taken by the wrong strategy");
   pollFail_a: assert property (@(posedge core_clk) disable iff (rst)
      ((s.st == S_POLLHI || s.st == S_POLLLO) && accDone && fail)
      |=> s.st == S_IDLE && s.failed && !s.busy)
      else $error("poll limit did not end the sequence as failed");
   haltedAtEnd_a: assert property (@(posedge core_clk) disable iff (rst)
      ($fell(s.busy) && !s.failed) |-> s.halted && !s.rstOe)
      else $error("sequence ended without the cpu halted");
endmodule : debug_reset_strategy_sequencer
`default_nettype wire

/* File: design/link_rate_monitor.sv */
// measures the link clock period and flags a link slower than the minimum rate
`timescale 1ns/1ps
`default_nettype none
module link_rate_monitor
   import reset_seq_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // synchronised link clock
   input wire logic linkClkSync,
   // result
   output logic slowLink
);
   typedef struct packed {
      logic prev;
      logic [RATE_W-1:0] cnt;
      logic slow;
   } rate_t;

   rate_t s;
   rate_t n;

   always_comb begin
      n = s;
      n.prev = linkClkSync;
      if (linkClkSync && !s.prev) begin
         n.slow = (s.cnt > LINK_MAX_CYC);
         n.cnt = '0;
      end else if (s.cnt <= LINK_MAX_CYC) begin
         n.cnt = s.cnt + 8'h01;
      end else begin
         // a stopped clock counts as slow too
         n.slow = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign slowLink = s.slow;
endmodule : link_rate_monitor
`default_nettype wire

/* File: include/reset_seq_pkg.sv */
// shared constants and types for the debug reset-and-halt sequencer
package reset_seq_pkg;

   // clock and timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int CNT_W = 16;
   localparam int PIN_HOLD_NS = 20000;
   localparam logic [CNT_W-1:0] PIN_HOLD_CYC =
      CNT_W'((PIN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int LINK_MIN_FREQ_KHZ = 1000;
   localparam int LINK_MAX_PERIOD_NS = 1000000 / LINK_MIN_FREQ_KHZ;
   localparam int RATE_W = 8;
   localparam logic [RATE_W-1:0] LINK_MAX_CYC = RATE_W'(LINK_MAX_PERIOD_NS / CLK_PERIOD_NS);

   // register bus
   localparam int REG_AW = 8;
   localparam int DW = 32;
   localparam logic [REG_AW-1:0] OFF_CTRL = 8'h00;
   localparam logic [REG_AW-1:0] OFF_STATUS = 8'h04;
   localparam logic [REG_AW-1:0] OFF_POLL_LIMIT = 8'h08;
   localparam logic [REG_AW-1:0] OFF_BOOT_WAIT = 8'h0c;
   localparam logic [REG_AW-1:0] OFF_WDOG_ADDR = 8'h10;
   localparam logic [REG_AW-1:0] OFF_WDOG_DATA = 8'h14;
   localparam logic [REG_AW-1:0] OFF_IRQ_STATUS = 8'h18;
   localparam logic [REG_AW-1:0] OFF_IRQ_CLEAR = 8'h1c;
   localparam logic [REG_AW-1:0] OFF_IRQ_ENABLE = 8'h20;
   localparam logic [REG_AW-1:0] OFF_LAST_RDATA = 8'h24;

   // control register fields
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STRAT_LSB = 4;
   localparam int STRAT_W = 4;
   localparam int CTRL_SWD_BIT = 8;
   localparam int CTRL_BOOTROM_BIT = 9;

   // status register fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_HALTED_BIT = 1;
   localparam int STAT_FAILED_BIT = 2;
   localparam int STAT_SLOW_BIT = 3;

   // interrupt bits
   localparam int IRQ_W = 3;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FAIL = 1;
   localparam int IRQ_SLOW = 2;

   // reset values
   localparam logic [CNT_W-1:0] POLL_LIMIT_DEF = 16'h0100;
   localparam logic [CNT_W-1:0] BOOT_WAIT_DEF = 16'h1000;

   // strategy numbers
   localparam logic [STRAT_W-1:0] STRAT_NORMAL = 4'h0;
   localparam logic [STRAT_W-1:0] STRAT_CORE = 4'h1;
   localparam logic [STRAT_W-1:0] STRAT_PIN = 4'h2;
   localparam logic [STRAT_W-1:0] STRAT_UNDER_RST = 4'h3;
   localparam logic [STRAT_W-1:0] STRAT_AFTER_BOOT = 4'h4;
   localparam logic [STRAT_W-1:0] STRAT_BEFORE_BOOT = 4'h5;
   localparam logic [STRAT_W-1:0] STRAT_WDOG_A = 4'h6;
   localparam logic [STRAT_W-1:0] STRAT_KERNEL = 4'h7;
   localparam logic [STRAT_W-1:0] STRAT_SYSTEM = 4'h8;
   localparam logic [STRAT_W-1:0] STRAT_BOOT_WDOG = 4'h9;
   localparam logic [STRAT_W-1:0] STRAT_WDOG_B = 4'ha;
   localparam logic [STRAT_W-1:0] STRAT_MAX = 4'ha;

   // target debug registers
   localparam logic [DW-1:0] ADDR_DEBUG_EXC_MON_CTRL = 32'he000edfc;
   localparam logic [DW-1:0] ADDR_APP_INT_RST_CTRL = 32'he000ed0c;
   localparam logic [DW-1:0] ADDR_DEBUG_HALT_CTRL_STATUS = 32'he000edf0;
   localparam logic [DW-1:0] CORE_RESET_VECTOR_CATCH = 32'h00000001;
   localparam logic [DW-1:0] RST_CTRL_KEY = 32'h05fa0000;
   localparam logic [DW-1:0] SYSTEM_RESET_REQUEST = 32'h00000004;
   localparam logic [DW-1:0] LOCAL_CORE_RESET_REQUEST = 32'h00000001;
   localparam logic [DW-1:0] HALT_CTRL_KEY = 32'ha05f0000;
   localparam logic [DW-1:0] HALT_DEBUG_EN = 32'h00000001;
   localparam logic [DW-1:0] HALT_REQUEST = 32'h00000002;
   localparam int RESET_STICKY_STATUS_BIT = 25;

   // sequencer states
   typedef enum logic [9:0] {
      S_IDLE = 10'h001,
      S_PIN = 10'h002,
      S_VC = 10'h004,
      S_RST = 10'h008,
      S_POLLHI = 10'h010,
      S_POLLLO = 10'h020,
      S_BOOT = 10'h040,
      S_HALT = 10'h080,
      S_CLRVC = 10'h100,
      S_WDOG = 10'h200
   } seq_state_t;

endpackage : reset_seq_pkg

/* File: sim/debug_reset_strategy_sequencer_tb.sv */
// self-checking bench: runs reset strategies against the target port model
`timescale 1ns/1ps
`default_nettype none
module debug_reset_strategy_sequencer_tb import reset_seq_pkg::*;;
   logic core_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, linkClk = 1'b0;
   logic [REG_AW-1:0] regAddr = '0;
   logic [DW-1:0] regWdata = '0, regRdata, apAddr, apWdata, apRdata, wd;
   logic apReq, apWrite, apAck, linkSwd, tgtResetOut, tgtResetOe, irq, rdPend = 1'b0;
   logic [DW-1:0] expQ[$];
   int fail_count = 0, compares = 0, n;
   initial forever #4 core_clk = ~core_clk;
   initial forever #80 linkClk = ~linkClk;
   debug_reset_strategy_sequencer dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .apReq(apReq),
      .apWrite(apWrite), .apAddr(apAddr), .apWdata(apWdata), .apAck(apAck), .apRdata(apRdata),
      .linkSwd(linkSwd), .linkClk(linkClk), .tgtResetOut(tgtResetOut),
      .tgtResetOe(tgtResetOe), .irq(irq));
   target_dap_model m (.core_clk(core_clk), .apReq(apReq), .apWrite(apWrite), .apAddr(apAddr),
      .apWdata(apWdata), .apAck(apAck), .apRdata(apRdata), .tgtResetOe(tgtResetOe));
   task automatic check(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      if (fail_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   // read data stand only in the cycle after the strobe
   always @(posedge core_clk) begin
      if (rdPend) check("regRdata", regRdata, expQ.pop_front());
      rdPend <= regRd;
   end
   task automatic wr(input logic [REG_AW-1:0] a, input logic [DW-1:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [REG_AW-1:0] a, input logic [DW-1:0] e);
      expQ.push_back(e);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      @(posedge core_clk);
   endtask : rd
   task automatic run(input logic [3:0] s, input logic [CNT_W-1:0] lim, input logic bad);
      wd = $urandom();
      wr(OFF_POLL_LIMIT, {16'h0, lim});
      wr(OFF_WDOG_DATA, wd);
      // transport alternates with strategy parity
      wr(OFF_CTRL, {22'h0, 1'b0, s[0], s, 3'h0, 1'b1});
      for (n = 0; n < 20000 && irq !== 1'b1; n++) @(posedge core_clk);
      if (n == 20000) begin
         fail_count++;
         print_verdict();
      end
      check("linkSwd", DW'(linkSwd), DW'(s[0]));
      rd(OFF_STATUS, bad ? 32'h4 : 32'h2);
      rd(OFF_IRQ_STATUS, bad ? 32'h2 : 32'h1);
      if (!bad && s inside {4'h0, 4'h1, 4'h5, 4'h8, 4'ha})
         check("order", DW'(m.orderOk), 32'h1);
      if (!bad) check("vcClear", DW'(m.vcArmed), 32'h0);
      if (s == STRAT_WDOG_B || s == STRAT_BOOT_WDOG) check("wdog", m.lastWr, wd);
      if (s == STRAT_AFTER_BOOT)
         check("halt", m.lastWr, HALT_CTRL_KEY | HALT_REQUEST | HALT_DEBUG_EN);
      wr(OFF_IRQ_CLEAR, 32'h7);
      @(posedge core_clk);
      check("irqClr", DW'(irq), 32'h0);
   endtask : run
   initial begin
      static logic [3:0] strats[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb};
      void'($urandom(83711));
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      wr(OFF_IRQ_ENABLE, 32'h3);
      wr(OFF_WDOG_ADDR, 32'h40001000);
      rd(8'h30, 32'h0);
      foreach (strats[i]) run(strats[i], 16'h0100, strats[i] > STRAT_MAX);
      run(STRAT_SYSTEM, 16'h0002, 1'b1);
      repeat (2) @(posedge core_clk);
      print_verdict();
   end
endmodule : debug_reset_strategy_sequencer_tb
`default_nettype wire

/* File: sim/target_dap_model.sv */
// behavioural target debug port: answers accesses, models reset status
`timescale 1ns/1ps
`default_nettype none
module target_dap_model
   import reset_seq_pkg::*;
(
   // clock
   input wire logic core_clk,
   // access handshake
   input wire logic apReq,
   input wire logic apWrite,
   input wire logic [DW-1:0] apAddr,
   input wire logic [DW-1:0] apWdata,
   output logic apAck,
   output logic [DW-1:0] apRdata,
   // reset pin
   input wire logic tgtResetOe
);
   int rstLeft = 0;
   logic vcArmed = 1'b0;
   logic orderOk = 1'b0;
   logic [DW-1:0] lastWr = '0;
   initial begin
      apAck = 1'b0;
      apRdata = '0;
      forever begin
         @(posedge core_clk);
         if (tgtResetOe) rstLeft = 3; // pin reset raises the status
         if (apReq) begin
            repeat ($urandom_range(3)) @(posedge core_clk);
            if (apWrite && apAddr === ADDR_DEBUG_EXC_MON_CTRL) vcArmed = apWdata[0];
            if (apWrite && apAddr === ADDR_APP_INT_RST_CTRL) begin
               orderOk = vcArmed;
               rstLeft = 3;
            end
            if (apWrite) lastWr = apWdata;
            // status reads high a few times, then low
            apRdata <= {6'h0, rstLeft > 0, 25'h0};
            if (!apWrite && apAddr === ADDR_DEBUG_HALT_CTRL_STATUS && rstLeft > 0) rstLeft--;
            @(posedge core_clk);
            apAck <= 1'b1;
            while (apReq) @(posedge core_clk);
            apAck <= 1'b0;
            // released data must not look valid
            apRdata <= ~apRdata;
         end
      end
   end
endmodule : target_dap_model
`default_nettype wire
